// file: rtl/pwmc_core.sv
// six-channel three-pair wave generator with apb register slave
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pwmc_core #(
    parameter int unsigned ADDR_W = 12
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic [5:0] WAVE_PRI_O,
    output logic [5:0] WAVE_PRI_OE,
    output logic [5:0] WAVE_ALT_O,
    output logic [5:0] WAVE_ALT_OE
);
    localparam int unsigned NCH = pwmc_pkg::NUM_CH;
    localparam int unsigned NPR = pwmc_pkg::NUM_PAIR;

    // address bus must reach the highest word and fit in 32 bits
    generate
        if (ADDR_W < pwmc_pkg::IDX_W + pwmc_pkg::ADDR_LSB || ADDR_W > 32)
        begin : g_bad_addr
            $error("pwmc_core: ADDR_W out of range");
        end
    endgenerate

    typedef struct packed {
        logic [5:0][15:0] duty;
        logic [15:0] period;
        logic [7:0] con1;
        logic run;
        logic [5:0] pri;
        logic [5:0] alt;
        logic [8:0] dt_cnt;
        logic [2:0] dt_en;
        logic [5:0] mask_en;
        logic [5:0] mask_dat;
        pwmc_pkg::pwmc_ta_e ta;
        logic [6:0] div_cnt;
        logic [15:0] cnt;
        logic down;
        logic [5:0] gen;
        logic [5:0] out;
        logic [31:0] prdata;
        logic slverr;
    } pwmc_core_s;

    pwmc_core_s q;
    pwmc_core_s n;

    // word index of a bus address, with a valid flag on top
    function automatic logic [8:0] word_index(input logic [ADDR_W-1:0] a);
        logic ok;
        ok = (a[pwmc_pkg::ADDR_LSB-1:0] == '0);
        if (ADDR_W > pwmc_pkg::IDX_W + pwmc_pkg::ADDR_LSB)
            ok = ok && ((a >> (pwmc_pkg::IDX_W + pwmc_pkg::ADDR_LSB)) == '0);
        return {ok, a[pwmc_pkg::IDX_W+pwmc_pkg::ADDR_LSB-1:
                      pwmc_pkg::ADDR_LSB]};
    endfunction : word_index

    // read value of one register, hit flag on top
    function automatic logic [8:0] read_reg(input pwmc_core_s s,
                                            input logic [7:0] idx);
        logic [8:0] r;
        r = 9'h000;
        if (idx == pwmc_pkg::IDX_PERIOD_HI)
            r = {1'b1, s.period[15:8]};
        else if (idx == pwmc_pkg::IDX_PERIOD_LO)
            r = {1'b1, s.period[7:0]};
        else if (idx == pwmc_pkg::IDX_CON1)
            r = {1'b1, s.con1};
        else if (idx == pwmc_pkg::IDX_CON0)
            r = {1'b1, s.run, 7'h00};
        else if (idx == pwmc_pkg::IDX_PRI_ROUTE)
            r = {3'b100, s.pri};
        else if (idx == pwmc_pkg::IDX_ALT_ROUTE)
            r = {3'b100, s.alt};
        else if (idx == pwmc_pkg::IDX_DT_CNT)
            r = {1'b1, s.dt_cnt[7:0]};
        else if (idx == pwmc_pkg::IDX_DT_EN)
            r = {4'b1000, s.dt_cnt[8], 1'b0, s.dt_en};
        else if (idx == pwmc_pkg::IDX_MASK_EN)
            r = {3'b100, s.mask_en};
        else if (idx == pwmc_pkg::IDX_MASK_DAT)
            r = {3'b100, s.mask_dat};
        else if (idx == pwmc_pkg::IDX_TIMED_ACCESS)
            r = {8'h80, s.ta == pwmc_pkg::TA_OPEN};
        for (int i = 0; i < NCH; i++)
        begin
            if (idx == pwmc_pkg::IDX_DUTY_LO[i])
                r = {1'b1, s.duty[i][7:0]};
            if (idx == pwmc_pkg::IDX_DUTY_HI[i])
                r = {1'b1, s.duty[i][15:8]};
        end
        return r;
    endfunction : read_reg

    logic setup;
    logic wr;
    logic [8:0] dec;
    logic [7:0] idx;
    logic [7:0] wbyte;
    logic [8:0] rd;
    logic tick;
    logic [6:0] div_mask;
    logic center;
    pwmc_pkg::pwmc_mode_e mode;
    logic [5:0] masked;
    logic [5:0] mode_out;

    // bus request decode
    assign setup = PSEL & ~PENABLE;
    assign wr = PSEL & PENABLE & PWRITE;
    assign dec = word_index(PADDR);
    assign idx = dec[7:0];
    assign wbyte = PWDATA[7:0];
    assign rd = read_reg(q, idx);

    // clock divider by a power of two gives the counting tick
    assign div_mask = 7'((8'h01 << q.con1[pwmc_pkg::DIV_HI:pwmc_pkg::DIV_LO])
                         - 8'h01);
    assign tick = q.run & ((q.div_cnt & div_mask) == div_mask);
    assign center = q.con1[pwmc_pkg::TYPE_BIT];
    assign mode = pwmc_pkg::pwmc_mode_e'(
        q.con1[pwmc_pkg::MODE_HI:pwmc_pkg::MODE_LO]);

    // mask stage forces a level before the mode stage sees it
    assign masked = (q.gen & ~q.mask_en) | (q.mask_dat & q.mask_en);

    // mode stage per pair, dead-time inserted in complementary mode
    generate
        for (genvar p = 0; p < NPR; p++)
        begin : g_pair
            pwmc_dt_if dt ();
            assign dt.enable = q.dt_en[p] &
                               (mode == pwmc_pkg::MODE_COMPL);
            assign dt.count = q.dt_cnt;
            assign dt.lead = masked[2*p];
            pwmc_deadtime u_dt (
                .clk(CLK),
                .arst_n(ARST_N),
                .dt(dt.unit)
            );
            always_comb
            begin
                case (mode)
                    pwmc_pkg::MODE_COMPL:
                    begin
                        mode_out[2*p] = dt.out_lead;
                        mode_out[2*p+1] = dt.out_trail;
                    end
                    pwmc_pkg::MODE_SYNC:
                    begin
                        mode_out[2*p] = masked[2*p];
                        mode_out[2*p+1] = masked[2*p];
                    end
                    default:
                    begin
                        mode_out[2*p] = masked[2*p];
                        mode_out[2*p+1] = masked[2*p+1];
                    end
                endcase
            end
        end
    endgenerate

    // next-state logic: bus, timed access, counter and generators
    always_comb
    begin
        n = q;
        n.out = mode_out;
        n.div_cnt = q.run ? 7'(q.div_cnt + 7'h01) : 7'h00;
        // read data and error latched in the setup cycle
        if (setup)
        begin
            n.prdata = {24'h000000, rd[7:0]};
            n.slverr = ~(dec[8] & rd[8]);
        end
        // register writes take effect in the access cycle
        if (wr && dec[8])
        begin
            if (idx == pwmc_pkg::IDX_TIMED_ACCESS)
            begin
                if (wbyte == pwmc_pkg::TA_KEY1)
                    n.ta = pwmc_pkg::TA_FIRST;
                else if (wbyte == pwmc_pkg::TA_KEY2 &&
                         q.ta == pwmc_pkg::TA_FIRST)
                    n.ta = pwmc_pkg::TA_OPEN;
                else
                    n.ta = pwmc_pkg::TA_IDLE;
            end
            else
            begin
                n.ta = pwmc_pkg::TA_IDLE; // grant spent by any write
            end
            if (idx == pwmc_pkg::IDX_PERIOD_HI)
                n.period[15:8] = wbyte;
            else if (idx == pwmc_pkg::IDX_PERIOD_LO)
                n.period[7:0] = wbyte;
            else if (idx == pwmc_pkg::IDX_CON1)
                n.con1 = wbyte;
            else if (idx == pwmc_pkg::IDX_CON0)
                n.run = wbyte[pwmc_pkg::RUN_BIT];
            else if (idx == pwmc_pkg::IDX_PRI_ROUTE)
                n.pri = wbyte[5:0];
            else if (idx == pwmc_pkg::IDX_ALT_ROUTE)
                n.alt = wbyte[5:0] & pwmc_pkg::ALT_ROUTE_MASK;
            else if (idx == pwmc_pkg::IDX_DT_CNT &&
                     q.ta == pwmc_pkg::TA_OPEN)
                n.dt_cnt[7:0] = wbyte;
            else if (idx == pwmc_pkg::IDX_DT_EN &&
                     q.ta == pwmc_pkg::TA_OPEN)
            begin
                n.dt_cnt[8] = wbyte[pwmc_pkg::DT_CNT8_BIT];
                n.dt_en = wbyte[2:0];
            end
            else if (idx == pwmc_pkg::IDX_MASK_EN)
                n.mask_en = wbyte[5:0];
            else if (idx == pwmc_pkg::IDX_MASK_DAT)
                n.mask_dat = wbyte[5:0];
            for (int i = 0; i < NCH; i++)
            begin
                if (idx == pwmc_pkg::IDX_DUTY_LO[i])
                    n.duty[i][7:0] = wbyte;
                if (idx == pwmc_pkg::IDX_DUTY_HI[i])
                    n.duty[i][15:8] = wbyte;
            end
        end
        // stopped: counter parked at zero counting up, generators low
        if (!q.run)
        begin
            n.cnt = 16'h0000;
            n.down = 1'b0;
            n.gen = 6'h00;
        end
        else if (tick)
        begin
            // generators compare the count held before this tick
            for (int i = 0; i < NCH; i++)
            begin
                if (!center)
                begin
                    if (q.cnt == 16'h0000)
                        n.gen[i] = 1'b1;
                    if (q.cnt == q.duty[i])
                        n.gen[i] = 1'b0;
                end
                else if (q.cnt == q.duty[i])
                begin
                    n.gen[i] = q.down;
                end
            end
            if (!center)
            begin
                n.down = 1'b0;
                if (q.cnt >= q.period)
                    n.cnt = 16'h0000;
                else
                    n.cnt = 16'(q.cnt + 16'h0001);
            end
            else if (!q.down)
            begin
                if (q.cnt >= q.period)
                begin
                    n.down = 1'b1;
                    n.cnt = 16'(q.period - 16'h0001);
                end
                else
                    n.cnt = 16'(q.cnt + 16'h0001);
            end
            else
            begin
                if (q.cnt == 16'h0000)
                begin
                    n.down = 1'b0;
                    n.cnt = 16'h0001;
                end
                else
                    n.cnt = 16'(q.cnt - 16'h0001);
            end
        end
    end

    // all core state except the dead-time units in one register
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            q <= '0;
        else
            q <= n;
    end

    // outputs: channel level on each routed pin, enable while routed
    assign PRDATA = q.prdata;
    assign PSLVERR = q.slverr;
    assign PREADY = 1'b1; // zero wait states
    assign WAVE_PRI_O = q.out;
    assign WAVE_PRI_OE = q.pri;
    assign WAVE_ALT_O = q.out & pwmc_pkg::ALT_ROUTE_MASK;
    assign WAVE_ALT_OE = q.alt;
endmodule : pwmc_core
`default_nettype wire

// file: rtl/pwmc_pkg.sv
// shared constants and types of the six-channel wave generator
package pwmc_pkg;
    localparam int unsigned NUM_CH = 6;
    localparam int unsigned NUM_PAIR = 3;
    localparam int unsigned ADDR_LSB = 2;
    localparam int unsigned IDX_W = 8;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_PERIOD_HI = 8'hD1;
    localparam logic [7:0] IDX_PERIOD_LO = 8'hD9;
    localparam logic [5:0][7:0] IDX_DUTY_LO =
        {8'hCD, 8'hCC, 8'hDD, 8'hDC, 8'hDB, 8'hDA};
    localparam logic [5:0][7:0] IDX_DUTY_HI =
        {8'hC5, 8'hC4, 8'hD5, 8'hD4, 8'hD3, 8'hD2};
    localparam logic [7:0] IDX_ALT_ROUTE = 8'hC6;
    localparam logic [7:0] IDX_TIMED_ACCESS = 8'hC7;
    localparam logic [7:0] IDX_CON0 = 8'hD8;
    localparam logic [7:0] IDX_PRI_ROUTE = 8'hDE;
    localparam logic [7:0] IDX_CON1 = 8'hDF;
    localparam logic [7:0] IDX_DT_EN = 8'hF9;
    localparam logic [7:0] IDX_DT_CNT = 8'hFA;
    localparam logic [7:0] IDX_MASK_EN = 8'hFB;
    localparam logic [7:0] IDX_MASK_DAT = 8'hFC;
    // field positions
    localparam int unsigned MODE_HI = 7;
    localparam int unsigned MODE_LO = 6;
    localparam int unsigned TYPE_BIT = 4;
    localparam int unsigned FAULT_EN_BIT = 3;
    localparam int unsigned DIV_HI = 2;
    localparam int unsigned DIV_LO = 0;
    localparam int unsigned RUN_BIT = 7;
    localparam int unsigned DT_CNT8_BIT = 4;
    localparam logic [5:0] ALT_ROUTE_MASK = 6'h2E;
    // timed-access keys
    localparam logic [7:0] TA_KEY1 = 8'hAA;
    localparam logic [7:0] TA_KEY2 = 8'h55;
    typedef enum logic [1:0] {
        MODE_INDEP = 2'b00,
        MODE_COMPL = 2'b01,
        MODE_SYNC = 2'b10,
        MODE_RSVD = 2'b11
    } pwmc_mode_e;
    typedef enum logic [1:0] {
        TA_IDLE = 2'b00,
        TA_FIRST = 2'b01,
        TA_OPEN = 2'b10
    } pwmc_ta_e;
endpackage : pwmc_pkg

// file: rtl/pwmc_dt_if.sv
// link between the core and one pair's dead-time unit
`timescale 1ns/1ps
`default_nettype none
interface pwmc_dt_if;
    logic enable;
    logic [8:0] count;
    logic lead;
    logic out_lead;
    logic out_trail;
    modport ctrl (output enable, output count, output lead,
                  input out_lead, input out_trail);
    modport unit (input enable, input count, input lead,
                  output out_lead, output out_trail);
endinterface : pwmc_dt_if
`default_nettype wire

// file: rtl/pwmc_deadtime.sv
// dead-time inserter for one complementary pair
`timescale 1ns/1ps
`default_nettype none
module pwmc_deadtime (
    input wire logic clk,
    input wire logic arst_n,
    pwmc_dt_if.unit dt
);
    typedef struct packed {
        logic lead_prev;
        logic busy;
        logic [8:0] cnt;
    } pwmc_dt_s;
    pwmc_dt_s q;
    pwmc_dt_s n;
    logic change;
    logic hold;

    // both sides held low from the edge for count plus one clocks
    assign change = dt.lead ^ q.lead_prev;
    assign hold = dt.enable & (q.busy | change);
    assign dt.out_lead = dt.lead & ~hold;
    assign dt.out_trail = ~dt.lead & ~hold;

    // down-counter loads on every lead edge, releases when it reaches zero
    always_comb
    begin
        n = q;
        n.lead_prev = dt.lead;
        if (!dt.enable)
        begin
            n.busy = 1'b0;
            n.cnt = '0;
        end
        else if (change)
        begin
            n.cnt = dt.count;
            n.busy = (dt.count != 9'h000);
        end
        else if (q.busy)
        begin
            n.cnt = 9'(q.cnt - 9'h001);
            n.busy = (q.cnt != 9'h001);
        end
    end

    // state register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            q <= '0;
        else
            q <= n;
    end
endmodule : pwmc_deadtime
`default_nettype wire

// file: testbench/pwmc_core_properties.sv
// port-level checker of the wave generator, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module pwmc_chk #(
    parameter int unsigned ADDR_W = 12
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [5:0] WAVE_PRI_O,
    input wire logic [5:0] WAVE_PRI_OE,
    input wire logic [5:0] WAVE_ALT_O,
    input wire logic [5:0] WAVE_ALT_OE
);
    logic wr;
    logic [7:0] con1_q;
    logic run_q;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    // a write that completes at this edge and is not refused
    assign wr = PSEL && PENABLE && PWRITE && PREADY && !PSLVERR;
    // shadow of mode, type and run, so rules can be keyed on them
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            con1_q <= 8'h00;
            run_q <= 1'b0;
        end
        else if (wr && PADDR[9:2] == pwmc_pkg::IDX_CON1)
            con1_q <= PWDATA[7:0];
        else if (wr && PADDR[9:2] == pwmc_pkg::IDX_CON0)
            run_q <= PWDATA[7];
    end
    a_ready_high: assert property (PREADY)
        else $error("ready dropped");
    a_upper_zero: assert property (PRDATA[31:8] == 24'h000000)
        else $error("read data upper bits set");
    a_misalign_err: assert property (PSEL && !PENABLE && PADDR[1:0] != 2'h0
        |=> PSLVERR) else $error("misaligned access not refused");
    a_alt_oe_fixed: assert property (
        (WAVE_ALT_OE & ~pwmc_pkg::ALT_ROUTE_MASK) == 6'h00)
        else $error("alternate enable on a pin without alternate");
    a_alt_wave_copy: assert property (
        WAVE_ALT_O == (WAVE_PRI_O & pwmc_pkg::ALT_ROUTE_MASK))
        else $error("alternate level differs from channel");
    a_pri_route_wr: assert property (
        wr && PADDR[9:2] == pwmc_pkg::IDX_PRI_ROUTE
        |-> ##2 WAVE_PRI_OE == $past(PWDATA[5:0], 2))
        else $error("primary enables do not follow route write");
    a_alt_route_wr: assert property (
        wr && PADDR[9:2] == pwmc_pkg::IDX_ALT_ROUTE |-> ##2
        WAVE_ALT_OE == ($past(PWDATA[5:0], 2) & pwmc_pkg::ALT_ROUTE_MASK))
        else $error("alternate enables do not follow route write");
    a_stop_low: assert property (
        (!run_q && con1_q[7:6] != 2'b01) [*3] |-> WAVE_PRI_O == 6'h00)
        else $error("wave moves while stopped");
    a_pair_no_overlap: assert property (
        (con1_q[7:6] == 2'b01) [*3]
        |-> (WAVE_PRI_O & (WAVE_PRI_O >> 1) & 6'h15) == 6'h00)
        else $error("both sides of a pair high");
    a_sync_copy: assert property (
        (con1_q[7:6] == 2'b10) [*3] |-> {WAVE_PRI_O[5], WAVE_PRI_O[3],
        WAVE_PRI_O[1]} == {WAVE_PRI_O[4], WAVE_PRI_O[2], WAVE_PRI_O[0]})
        else $error("odd channel not in phase with partner");
    c_center: cover property (con1_q[4] && $rose(WAVE_PRI_O[0]));
    c_compl: cover property (con1_q[7:6] == 2'b01 && $rose(WAVE_PRI_O[1]));
    c_sync: cover property (con1_q[7:6] == 2'b10 && WAVE_PRI_O[1]);
endmodule : pwmc_chk
bind pwmc_core pwmc_chk #(.ADDR_W(ADDR_W)) u_chk (.CLK(CLK),
    .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .WAVE_PRI_O(WAVE_PRI_O),
    .WAVE_PRI_OE(WAVE_PRI_OE), .WAVE_ALT_O(WAVE_ALT_O),
    .WAVE_ALT_OE(WAVE_ALT_OE));
`default_nettype wire

// file: testbench/pwmc_switch_model.sv
// half-bridge switch drivers hanging on the wave pins
`timescale 1ns/1ps
`default_nettype none
module pwmc_switch_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [5:0] pri_o,
    input wire logic [5:0] pri_oe,
    input wire logic [5:0] alt_o,
    input wire logic [5:0] alt_oe,
    output logic [5:0] gate,
    output logic [15:0] shoot_cnt
);
    // a pin left to port use is pulled low by the gate driver
    assign gate = (pri_o & pri_oe) | (alt_o & alt_oe);
    // count cycles in which both switches of one bridge conduct
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            shoot_cnt <= 16'h0000;
        else if ((gate & (gate >> 1) & 6'h15) != 6'h00)
            shoot_cnt <= shoot_cnt + 16'h0001;
    end
endmodule : pwmc_switch_model
`default_nettype wire

// file: testbench/pwmc_core_tb.sv
// self-checking bench of the wave generator over its register bus
`timescale 1ns/1ps
`default_nettype none
module pwmc_core_tb;
    logic CLK, ARST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, rerr;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rdat;
    logic [5:0] WAVE_PRI_O, WAVE_PRI_OE, WAVE_ALT_O, WAVE_ALT_OE, gate;
    logic [15:0] shoot, s0;
    logic [3:0][7:0] mexp = {8'd2, 8'd1, 8'd9, 8'd2};
    int miscompares, n_compared;
    pwmc_core #(.ADDR_W(12)) DUT (.CLK(CLK), .ARST_N(ARST_N),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .WAVE_PRI_O(WAVE_PRI_O),
        .WAVE_PRI_OE(WAVE_PRI_OE), .WAVE_ALT_O(WAVE_ALT_O),
        .WAVE_ALT_OE(WAVE_ALT_OE));
    pwmc_switch_model u_sw (.clk(CLK), .arst_n(ARST_N),
        .pri_o(WAVE_PRI_O), .pri_oe(WAVE_PRI_OE), .alt_o(WAVE_ALT_O),
        .alt_oe(WAVE_ALT_OE), .gate(gate), .shoot_cnt(shoot));
    // 100 MHz clock
    always #5 CLK = ~CLK;
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    // one bus transfer: setup, then access held until ready
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        int n;
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= {24'h000000, d};
        @(posedge CLK);
        PENABLE <= 1'b1;
        n = 0;
        @(posedge CLK);
        while (PREADY !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge CLK);
        end
        if (n == 50)
        begin
            miscompares++;
            results();
        end
        rdat = PRDATA;
        rerr = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        apb(1'b1, {2'b00, i, 2'b00}, d);
    endtask : wr
    task automatic rd(input logic [7:0] i, input logic [7:0] e);
        apb(1'b0, {2'b00, i, 2'b00}, 8'h00);
        chk({rerr, rdat}, {1'b0, 24'h000000, e});
    endtask : rd
    // high and period cycles of one channel, taken from a settled period
    task automatic measure(input int ch, input int ehi, input int eper);
        int rises, hi, per;
        logic prv, cur;
        rises = 0;
        hi = 0;
        per = 0;
        prv = 1'b1;
        for (int n = 0; n < 3000 && rises < 3; n++)
        begin
            @(negedge CLK);
            cur = WAVE_PRI_O[ch];
            if (cur && !prv)
                rises++;
            if (rises == 2)
            begin
                per++;
                hi += int'(cur);
            end
            prv = cur;
        end
        if (rises < 3)
        begin
            miscompares++;
            results();
        end
        chk(hi, ehi);
        chk(per, eper);
    endtask : measure
    initial
    begin
        CLK = 1'b0;
        ARST_N = 1'b0;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 12'h000;
        PWDATA = 32'h00000000;
        miscompares = 0;
        n_compared = 0;
        repeat (2) @(posedge CLK);
        ARST_N <= 1'b1;
        rd(8'hDF, 8'h00);
        rd(8'hDE, 8'h00);
        rd(8'hC5, 8'h00);
        // unmapped read and misaligned write are refused
        apb(1'b0, 12'h000, 8'h00);
        chk({rerr, rdat}, {1'b1, 32'h00000000});
        apb(1'b1, 12'h37D, 8'hFF);
        chk(rerr, 1'b1);
        rd(8'hDF, 8'h00);
        wr(8'hDE, 8'h3F);
        wr(8'hC6, 8'h3F);
        repeat (2) @(negedge CLK);
        chk(WAVE_PRI_OE, 6'h3F);
        chk(WAVE_ALT_OE, 6'h2E);
        // edge type, period 9, duty n+1 on channel n
        wr(8'hD9, 8'h09);
        for (int n = 0; n < 6; n++)
            wr(pwmc_pkg::IDX_DUTY_LO[n], 8'(n + 1));
        wr(8'hD8, 8'h80);
        for (int n = 0; n < 6; n++)
            measure(n, n + 1, 10);
        wr(8'hDF, 8'h02);
        measure(0, 4, 40);
        wr(8'hDF, 8'h10);
        measure(0, 2, 18);
        for (int m = 0; m < 4; m++)
        begin
            wr(8'hDF, {m[1:0], 6'h00});
            measure(1, mexp[m], 10);
        end
        // dead-time writes without and with the access sequence
        wr(8'hFA, 8'h02);
        wr(8'hF9, 8'h01);
        rd(8'hFA, 8'h00);
        rd(8'hF9, 8'h00);
        wr(8'hC7, 8'hAA);
        wr(8'hC7, 8'h55);
        wr(8'hFA, 8'h02);
        wr(8'hC7, 8'hAA);
        wr(8'hC7, 8'h55);
        wr(8'hF9, 8'h01);
        wr(8'hC7, 8'hAA);
        wr(8'hC7, 8'h55);
        wr(8'hDF, 8'h40);
        wr(8'hFA, 8'h07);
        rd(8'hFA, 8'h02);
        rd(8'hF9, 8'h01);
        wr(8'hDA, 8'h05);
        s0 = shoot;
        measure(0, 2, 10);
        measure(1, 2, 10);
        chk(shoot - s0, 16'h0000);
        wr(8'hDF, 8'h80);
        measure(0, 5, 10);
        // mask forces channel 0 high before sync mode copies it
        wr(8'hFB, 8'h01);
        wr(8'hFC, 8'h01);
        repeat (2) @(negedge CLK);
        chk(WAVE_PRI_O[1:0], 2'b11);
        // reset in mid-run restores defaults
        @(posedge CLK);
        ARST_N <= 1'b0;
        repeat (2) @(posedge CLK);
        ARST_N <= 1'b1;
        rd(8'hDF, 8'h00);
        rd(8'hD8, 8'h00);
        chk(WAVE_PRI_OE, 6'h00);
        results();
    end
endmodule : pwmc_core_tb
`default_nettype wire
